// [design/dss_defs.svh]
// Constants for the drive sleep and fault supervisor.
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH
`define DSS_FB_VOLTAGE 2'h1
`define DSS_FB_CURRENT 2'h2
`define DSS_SLEEP_OFF 2'h0
`define DSS_SLEEP_TIMED 2'h1
`define DSS_SLEEP_INPUT 2'h2
`define DSS_DI_FAULT_RESET 6'h11
`define DSS_OC_PCT 16'h00C8
`define DSS_GF_PCT 16'h0032
`define DSS_PROT_ON 1'h1
`define DSS_CODE_NONE 4'h0
`define DSS_CODE_OC 4'h1
`define DSS_CODE_SC 4'h2
`define DSS_CODE_GF 4'h3
`define DSS_CODE_EXT 4'h4
`define DSS_STOP_COAST 2'h0
`define DSS_PCT_FULL 16'h0064
`define DSS_DIV_DEC1 16'h000A
`define DSS_DIV_DEC2 16'h0064
`define DSS_DIV_DEC3 16'h03E8
`define DSS_DIV_DEC4 16'h2710
`endif

// [design/dss_pkg.sv]
// Types for the drive sleep and fault supervisor.
package dss_pkg;
    typedef enum logic [1:0] {
        DSS_RUN = 2'b00,
        DSS_ASLEEP = 2'b01,
        DSS_FAULT = 2'b11
    } dss_state_t;
endpackage

// [design/dss_supervisor.sv]
// Drive sleep, wake-up and fault supervisor.
// Contract
// - Feedback type 1 selects the voltage input and type 2 selects the current-loop input.
// - The setpoint is scaled by a decimal-place count and full-scale value, with a unit code passed for display.
// - Sleep mode 0 disables sleep, 1 uses level and delay, and 2 lets a digital input enable sleep.
// - With sleep enabled the output turns off after the regulator output stays below the sleep level for the sleep delay.
// - While asleep the output resumes after the reference stays above the wake frequency for the wake delay.
// - A fault shows on the display, energizes the fault contact and by default coasts the motor.
// - The stop method on a fault can be chosen per fault type.
// - A warning shows its code without the fault output and clears by itself.
// - A digital input assigned function 17 clears a latched fault when activated.
// - The keypad reset key clears a latched fault.
// - Each fault records its code in a readable history.
// - Output current above 200 percent of rated raises an overcurrent fault.
// - Short circuit and ground fault detection act only when their enable is 1.
// - With ground protection on, ground current above 50 percent of rated raises a ground fault.
`timescale 1ns/1ns
`include "dss_defs.svh"
module dss_supervisor #(
    parameter int W = 16,
    parameter int TW = 24,
    parameter int HIST = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] fb_type,
    input wire logic [W-1:0] fb_voltage,
    input wire logic [W-1:0] fb_current,
    input wire logic [2:0] sp_decimals,
    input wire logic [W-1:0] sp_full_scale,
    input wire logic [3:0] sp_unit,
    input wire logic [W-1:0] sp_raw,
    input wire logic [1:0] sleep_mode,
    input wire logic [W-1:0] sleep_level,
    input wire logic [TW-1:0] sleep_delay,
    input wire logic [W-1:0] wake_freq,
    input wire logic [TW-1:0] wake_delay,
    input wire logic [W-1:0] pid_out,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_ground,
    input wire logic [W-1:0] i_rated,
    input wire logic sc_pin,
    input wire logic sc_prot_en,
    input wire logic gf_prot_en,
    input wire logic [1:0] stop_oc,
    input wire logic [1:0] stop_sc,
    input wire logic [1:0] stop_gf,
    input wire logic warn_pin,
    input wire logic [3:0] warn_code_in,
    input wire logic [5:0] di_function,
    input wire logic di_pin,
    input wire logic sleep_di_pin,
    input wire logic key_reset_pin,
    input wire logic [$clog2(HIST)-1:0] hist_index,
    output logic [W-1:0] fb_selected,
    output logic fb_valid,
    output logic [W-1:0] sp_scaled,
    output logic [3:0] sp_unit_out,
    output logic run_enable,
    output logic asleep,
    output logic fault_relay,
    output logic [3:0] display_fault,
    output logic [3:0] display_warn,
    output logic warn_active,
    output logic [1:0] stop_method,
    output logic [3:0] hist_code
);
    import dss_pkg::*;

    // Every pin crosses two flip-flops; the first stage is read only by the second.
    // A pin pulse shorter than one cycle may be missed, so the causes behind these pins must hold longer.
    logic [3:0] pin_m_q;
    logic [3:0] pin_s_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
        end else begin
            pin_m_q <= {key_reset_pin, di_pin, warn_pin, sc_pin};
            pin_s_q <= pin_m_q;
        end
    end
    logic sc_s;
    logic warn_s;
    logic di_s;
    logic key_s;
    assign sc_s = pin_s_q[0];
    assign warn_s = pin_s_q[1];
    assign di_s = pin_s_q[2];
    assign key_s = pin_s_q[3];

    // The sleep input has its own pair, so its delay does not depend on how the fault pins are grouped.
    logic slp_m_q;
    logic slp_s_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slp_m_q <= '0;
            slp_s_q <= '0;
        end else begin
            slp_m_q <= sleep_di_pin;
            slp_s_q <= slp_m_q;
        end
    end
    logic sleep_di_s;
    assign sleep_di_s = slp_s_q;

    // An unknown feedback type keeps the last word, so the regulator never sees a jump to zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fb_selected <= '0;
            fb_valid <= 1'b0;
        end else begin
            fb_valid <= (fb_type == `DSS_FB_VOLTAGE) || (fb_type == `DSS_FB_CURRENT);
            if (fb_type == `DSS_FB_CURRENT) begin
                fb_selected <= fb_current;
            end else if (fb_type == `DSS_FB_VOLTAGE) begin
                fb_selected <= fb_voltage;
            end
        end
    end

    // Scaled = raw * full_scale / 10^decimals, with decimals above 4 dividing by 10^4; the divide is by a small constant table.
    logic [2*W-1:0] sp_prod;
    logic [2*W-1:0] sp_div;
    always_comb begin
        sp_prod = (2*W)'(sp_raw) * (2*W)'(sp_full_scale);
        unique case (sp_decimals)
            3'h0: sp_div = sp_prod;
            3'h1: sp_div = sp_prod / (2*W)'(`DSS_DIV_DEC1);
            3'h2: sp_div = sp_prod / (2*W)'(`DSS_DIV_DEC2);
            3'h3: sp_div = sp_prod / (2*W)'(`DSS_DIV_DEC3);
            default: sp_div = sp_prod / (2*W)'(`DSS_DIV_DEC4);
        endcase
    end
    // The result is cut to W bits, so the operator must keep the scaled setpoint inside the word range.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sp_scaled <= '0;
            sp_unit_out <= 4'h0;
        end else begin
            sp_scaled <= sp_div[W-1:0];
            sp_unit_out <= sp_unit;
        end
    end

    // Current and regulator words come from logic on this clock, so they are compared without synchronisers.
    // Protection compares use percent of rated; wide products avoid overflow.
    logic [W+7:0] i_out_pct;
    logic [W+7:0] i_gnd_pct;
    logic [W+7:0] oc_lim;
    logic [W+7:0] gf_lim;
    logic oc_hit;
    logic sc_hit;
    logic gf_hit;
    logic reset_req;
    logic any_fault;
    always_comb begin
        i_out_pct = (W+8)'(i_out) * (W+8)'(`DSS_PCT_FULL);
        i_gnd_pct = (W+8)'(i_ground) * (W+8)'(`DSS_PCT_FULL);
        oc_lim = (W+8)'(i_rated) * (W+8)'(`DSS_OC_PCT);
        gf_lim = (W+8)'(i_rated) * (W+8)'(`DSS_GF_PCT);
    end
    assign oc_hit = i_out_pct > oc_lim;
    assign sc_hit = sc_s && (sc_prot_en == `DSS_PROT_ON);
    assign gf_hit = (gf_prot_en == `DSS_PROT_ON) && (i_gnd_pct > gf_lim);
    assign any_fault = oc_hit || sc_hit || gf_hit;
    // Reset requests are levels; a held key keeps asking, which is harmless once the fault has gone.
    assign reset_req = (di_s && (di_function == `DSS_DI_FAULT_RESET)) || key_s;

    logic sleep_cond;
    logic wake_cond;
    logic [TW-1:0] sleep_cnt_q;
    logic [TW-1:0] wake_cnt_q;
    dss_state_t state_q;
    // Both counters stop at their delay, so a long quiet spell cannot wrap them back below the threshold.
    assign sleep_cond = (sleep_mode == `DSS_SLEEP_TIMED) ? (pid_out < sleep_level) :
                        (sleep_mode == `DSS_SLEEP_INPUT) ? (sleep_di_s && (pid_out < sleep_level)) : 1'b0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_cnt_q <= '0;
        end else if (state_q != DSS_RUN || !sleep_cond) begin
            sleep_cnt_q <= '0;
        end else if (sleep_cnt_q < sleep_delay) begin
            sleep_cnt_q <= sleep_cnt_q + TW'(1'b1);
        end
    end

    // Wake-up watches the same regulator word as sleep, in the opposite direction.
    assign wake_cond = pid_out > wake_freq;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_cnt_q <= '0;
        end else if (state_q != DSS_ASLEEP || !wake_cond) begin
            wake_cnt_q <= '0;
        end else if (wake_cnt_q < wake_delay) begin
            wake_cnt_q <= wake_cnt_q + TW'(1'b1);
        end
    end

    // Only one code is taken per entry, so the highest-priority cause wins when several trip together.
    logic [3:0] new_code;
    logic [1:0] new_stop;
    always_comb begin
        new_code = `DSS_CODE_NONE;
        new_stop = `DSS_STOP_COAST;
        if (oc_hit) begin
            new_code = `DSS_CODE_OC;
            new_stop = stop_oc;
        end else if (sc_hit) begin
            new_code = `DSS_CODE_SC;
            new_stop = stop_sc;
        end else if (gf_hit) begin
            new_code = `DSS_CODE_GF;
            new_stop = stop_gf;
        end
    end

    // A fault present while reset is requested wins, so no event is lost.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= DSS_RUN;
            display_fault <= `DSS_CODE_NONE;
            stop_method <= `DSS_STOP_COAST;
        end else begin
            unique case (state_q)
                DSS_RUN: begin
                    if (any_fault) begin
                        state_q <= DSS_FAULT;
                        display_fault <= new_code;
                        stop_method <= new_stop;
                    end else if (sleep_cond && sleep_cnt_q >= sleep_delay) begin
                        state_q <= DSS_ASLEEP;
                    end
                end
                // Turning sleep off while asleep wakes the drive at once instead of waiting for the wake delay.
                DSS_ASLEEP: begin
                    if (any_fault) begin
                        state_q <= DSS_FAULT;
                        display_fault <= new_code;
                        stop_method <= new_stop;
                    end else if ((sleep_mode == `DSS_SLEEP_OFF) || (wake_cond && wake_cnt_q >= wake_delay)) begin
                        state_q <= DSS_RUN;
                    end
                end
                DSS_FAULT: begin
                    if (reset_req && !any_fault) begin
                        state_q <= DSS_RUN;
                        display_fault <= `DSS_CODE_NONE;
                        stop_method <= `DSS_STOP_COAST;
                    end
                end
                default: state_q <= DSS_FAULT;
            endcase
        end
    end

    // History is a ring; a fault is recorded once at entry to the fault state.
    // Once HIST faults are logged the oldest entry is overwritten.
    localparam int HW = $clog2(HIST);
    logic [3:0] hist_q [HIST];
    logic [$clog2(HIST)-1:0] hist_wr_q;
    logic fault_entry;
    assign fault_entry = any_fault && (state_q != DSS_FAULT);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hist_wr_q <= '0;
        end else if (fault_entry) begin
            hist_wr_q <= hist_wr_q + HW'(1'b1);
        end
    end
    genvar g;
    generate
        for (g = 0; g < HIST; g++) begin : g_hist
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    hist_q[g] <= `DSS_CODE_NONE;
                end else if (fault_entry && hist_wr_q == HW'(g)) begin
                    hist_q[g] <= new_code;
                end
            end
        end
    endgenerate

    // Warnings only mirror the synchronised pin, so they clear by themselves and never touch the state.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hist_code <= `DSS_CODE_NONE;
            display_warn <= `DSS_CODE_NONE;
            warn_active <= 1'b0;
        end else begin
            hist_code <= hist_q[hist_index];
            warn_active <= warn_s;
            display_warn <= warn_s ? warn_code_in : `DSS_CODE_NONE;
        end
    end

    // Outputs that gate the power stage decode the state register, so they move on the same edge as the state.
    assign run_enable = (state_q == DSS_RUN);
    assign asleep = (state_q == DSS_ASLEEP);
    assign fault_relay = (state_q == DSS_FAULT);
endmodule

// [dv/dss_supervisor_props.sv]
// Port assertions for the drive sleep and fault supervisor.
`timescale 1ns/1ns
module dss_supervisor_props #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] fb_type,
    input wire logic [1:0] sleep_mode,
    input wire logic [W-1:0] sleep_level,
    input wire logic [W-1:0] wake_freq,
    input wire logic [W-1:0] pid_out,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_ground,
    input wire logic [W-1:0] i_rated,
    input wire logic gf_prot_en,
    input wire logic fb_valid,
    input wire logic run_enable,
    input wire logic asleep,
    input wire logic fault_relay,
    input wire logic [3:0] display_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic oc_hit;
    logic gf_hit;
    // Widened to 32 bits so the percentage products cannot wrap.
    assign oc_hit = 32'(i_out) * 100 > 32'(i_rated) * 200;
    assign gf_hit = gf_prot_en && (32'(i_ground) * 100 > 32'(i_rated) * 50);
    a_oc_trip: assert property (oc_hit |=> fault_relay) else $error("overcurrent did not trip");
    a_gf_trip: assert property (gf_hit |=> fault_relay) else $error("ground leak did not trip");
    a_reset_refused: assert property (fault_relay && (oc_hit || gf_hit) |=> fault_relay)
        else $error("fault cleared while cause persists");
    a_oc_shown: assert property ($rose(fault_relay) && $past(oc_hit) |-> display_fault == 4'h1)
        else $error("overcurrent code not shown");
    a_output_off: assert property (!(fault_relay && asleep) && run_enable == !(fault_relay || asleep))
        else $error("output enable disagrees with state");
    a_mode_off: assert property (sleep_mode == 2'h0 |=> !asleep) else $error("asleep with sleep disabled");
    a_sleep_cause: assert property ($rose(asleep) |-> $past(pid_out) < $past(sleep_level))
        else $error("slept while output above level");
    a_wake_cause: assert property ($fell(asleep) && !fault_relay && $past(sleep_mode) != 2'h0
        |-> $past(pid_out) > $past(wake_freq)) else $error("woke while reference below wake level");
    a_fb_valid: assert property ($past(resetn) |-> fb_valid == ($past(fb_type) == 2'h1 || $past(fb_type) == 2'h2))
        else $error("feedback valid flag wrong");
endmodule
bind dss_supervisor dss_supervisor_props #(.W(W)) u_props (.clk(clk), .resetn(resetn), .fb_type(fb_type),
    .sleep_mode(sleep_mode), .sleep_level(sleep_level), .wake_freq(wake_freq), .pid_out(pid_out), .i_out(i_out),
    .i_ground(i_ground), .i_rated(i_rated), .gf_prot_en(gf_prot_en), .fb_valid(fb_valid), .run_enable(run_enable),
    .asleep(asleep), .fault_relay(fault_relay), .display_fault(display_fault));

// [dv/dss_plant.sv]
// Motor and feedback transducer model on the far side of the supervisor.
`timescale 1ns/1ns
module dss_plant (
    input wire logic run_enable,
    input wire logic [15:0] load,
    output logic [15:0] fb_voltage,
    output logic [15:0] fb_current,
    output logic [15:0] i_out
);
    // A coasting motor draws no current, which lets a tripped overcurrent clear.
    assign i_out = run_enable ? load : 16'h0000;
    assign fb_voltage = 16'h0123;
    assign fb_current = 16'h0456;
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the drive sleep and fault supervisor.
`timescale 1ns/1ns
`include "dss_defs.svh"
module tb_top;
    logic clk = 0;
    logic resetn = 0;
    logic [1:0] fb_type, sleep_mode, stop_oc, stop_sc, stop_gf, stop_method, hist_index;
    logic [2:0] sp_decimals;
    logic [3:0] sp_unit, warn_code_in, sp_unit_out, display_fault, display_warn, hist_code;
    logic [5:0] di_function;
    logic [15:0] sp_full_scale, sp_raw, sleep_level, wake_freq, pid_out, i_ground, i_rated, load;
    logic [15:0] fb_voltage, fb_current, i_out, fb_selected, sp_scaled;
    logic [23:0] sleep_delay, wake_delay;
    logic sc_pin, sc_prot_en, gf_prot_en, warn_pin, di_pin, sleep_di_pin, key_reset_pin;
    logic fb_valid, run_enable, asleep, fault_relay, warn_active;
    int n_fail = 0;
    int checks = 0;
    always #20 clk = ~clk;
    dss_plant plant (.run_enable(run_enable), .load(load), .fb_voltage(fb_voltage), .fb_current(fb_current),
        .i_out(i_out));
    dss_supervisor dut (.clk(clk), .resetn(resetn), .fb_type(fb_type), .fb_voltage(fb_voltage),
        .fb_current(fb_current), .sp_decimals(sp_decimals), .sp_full_scale(sp_full_scale), .sp_unit(sp_unit),
        .sp_raw(sp_raw), .sleep_mode(sleep_mode), .sleep_level(sleep_level), .sleep_delay(sleep_delay),
        .wake_freq(wake_freq), .wake_delay(wake_delay), .pid_out(pid_out), .i_out(i_out), .i_ground(i_ground),
        .i_rated(i_rated), .sc_pin(sc_pin), .sc_prot_en(sc_prot_en), .gf_prot_en(gf_prot_en), .stop_oc(stop_oc),
        .stop_sc(stop_sc), .stop_gf(stop_gf), .warn_pin(warn_pin), .warn_code_in(warn_code_in),
        .di_function(di_function), .di_pin(di_pin), .sleep_di_pin(sleep_di_pin), .key_reset_pin(key_reset_pin),
        .hist_index(hist_index), .fb_selected(fb_selected), .fb_valid(fb_valid), .sp_scaled(sp_scaled),
        .sp_unit_out(sp_unit_out), .run_enable(run_enable), .asleep(asleep), .fault_relay(fault_relay),
        .display_fault(display_fault), .display_warn(display_warn), .warn_active(warn_active),
        .stop_method(stop_method), .hist_code(hist_code));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic trip(input logic [3:0] code, input logic [1:0] stop);
        chk("relay", 16'h0001, fault_relay);
        chk("display_fault", code, display_fault);
        chk("stop_method", stop, stop_method);
        chk("run_enable", 16'h0000, run_enable);
    endtask
    task automatic key_clear;
        key_reset_pin = 1;
        cyc(2);
        key_reset_pin = 0;
        cyc(4);
    endtask
    task automatic t_feedback;
        fb_type = `DSS_FB_VOLTAGE;
        sp_raw = 16'h0032;
        sp_full_scale = 16'h2ee0;
        sp_decimals = 3'h1;
        sp_unit = 4'h2;
        cyc(3);
        chk("fb_volt", 16'h0123, fb_selected);
        chk("sp_scaled", 16'hea60, sp_scaled);
        chk("sp_unit", 16'h0002, sp_unit_out);
        fb_type = `DSS_FB_CURRENT;
        cyc(2);
        chk("fb_curr", 16'h0456, fb_selected);
        chk("fb_valid", 16'h0001, fb_valid);
        fb_type = 2'h3;
        cyc(2);
        chk("fb_invalid", 16'h0000, fb_valid);
    endtask
    task automatic t_sleep;
        sleep_level = 16'h0032;
        wake_freq = 16'h003c;
        sleep_delay = 24'h0005;
        wake_delay = 24'h0004;
        pid_out = 16'h000a;
        sleep_mode = `DSS_SLEEP_TIMED;
        cyc(4);
        pid_out = 16'h0064;
        cyc(1);
        pid_out = 16'h000a;
        cyc(4);
        chk("asleep_restart", 16'h0000, asleep);
        cyc(4);
        chk("asleep", 16'h0001, asleep);
        pid_out = 16'h0064;
        cyc(3);
        chk("wake_early", 16'h0001, asleep);
        pid_out = 16'h000a;
        cyc(1);
        pid_out = 16'h0064;
        cyc(4);
        chk("wake_restart", 16'h0001, asleep);
        cyc(4);
        chk("woken", 16'h0000, asleep);
        sleep_mode = `DSS_SLEEP_INPUT;
        pid_out = 16'h000a;
        cyc(10);
        chk("di_low", 16'h0000, asleep);
        sleep_di_pin = 1;
        cyc(10);
        chk("di_sleep", 16'h0001, asleep);
        sleep_mode = `DSS_SLEEP_OFF;
        cyc(2);
        chk("mode_off", 16'h0000, asleep);
        sleep_di_pin = 0;
    endtask
    task automatic t_faults;
        load = 16'h00c8;
        cyc(3);
        chk("oc_edge", 16'h0000, fault_relay);
        load = 16'h00c9;
        cyc(2);
        trip(`DSS_CODE_OC, 2'h1);
        load = 16'h0000;
        key_clear();
        chk("key_reset", 16'h0000, fault_relay);
        i_ground = 16'h0033;
        cyc(3);
        chk("gf_disabled", 16'h0000, fault_relay);
        gf_prot_en = 1;
        i_ground = 16'h0032;
        cyc(3);
        chk("gf_edge", 16'h0000, fault_relay);
        i_ground = 16'h0033;
        cyc(2);
        trip(`DSS_CODE_GF, 2'h3);
        key_clear();
        chk("held", 16'h0001, fault_relay);
        i_ground = 16'h0000;
        di_function = 6'h10;
        di_pin = 1;
        cyc(5);
        chk("wrong_di", 16'h0001, fault_relay);
        di_function = `DSS_DI_FAULT_RESET;
        cyc(5);
        chk("di_reset", 16'h0000, fault_relay);
        di_pin = 0;
        sc_pin = 1;
        cyc(5);
        chk("sc_disabled", 16'h0000, fault_relay);
        sc_prot_en = 1;
        cyc(4);
        trip(`DSS_CODE_SC, 2'h2);
        sc_pin = 0;
        key_clear();
        for (int i = 0; i < 3; i++) begin
            hist_index = 2'(i);
            cyc(2);
            chk("history", (i == 0) ? 16'h0001 : (i == 1) ? 16'h0003 : 16'h0002, hist_code);
        end
    endtask
    task automatic t_warning;
        warn_code_in = 4'h5;
        warn_pin = 1;
        cyc(4);
        chk("warn_on", 16'h0001, warn_active);
        chk("warn_code", 16'h0005, display_warn);
        chk("warn_relay", 16'h0000, fault_relay);
        warn_pin = 0;
        cyc(4);
        chk("warn_off", 16'h0000, warn_active);
        chk("warn_clear", 16'h0000, display_warn);
        chk("warn_run", 16'h0001, run_enable);
    endtask
    task automatic t_reset;
        hist_index = 2'h0;
        load = 16'h00c9;
        cyc(2);
        chk("pre_reset", 16'h0001, fault_relay);
        load = 16'h0000;
        resetn = 0;
        cyc(1);
        chk("rst_relay", 16'h0000, fault_relay);
        chk("rst_run", 16'h0001, run_enable);
        chk("rst_hist", 16'h0000, hist_code);
        resetn = 1;
        cyc(2);
        chk("post_relay", 16'h0000, fault_relay);
        chk("post_hist", 16'h0000, hist_code);
    endtask
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {fb_type, sleep_mode, hist_index, sp_decimals, sp_unit, warn_code_in, di_function, sp_full_scale} = '0;
        {sp_raw, sleep_level, wake_freq, pid_out, i_ground, load, sleep_delay, wake_delay} = '0;
        {sc_pin, sc_prot_en, gf_prot_en, warn_pin, di_pin, sleep_di_pin, key_reset_pin} = '0;
        i_rated = 16'h0064;
        stop_oc = 2'h1;
        stop_sc = 2'h2;
        stop_gf = 2'h3;
        cyc(3);
        resetn = 1;
        cyc(2);
        t_feedback();
        t_sleep();
        t_faults();
        t_warning();
        t_reset();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
